// [include/pfs_pkg.sv]
package pfs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PFS_PORT4_DATA    = 8'h00;
    localparam logic [7:0] PFS_PORT4_DIR     = 8'h01;
    localparam logic [7:0] PFS_PORT5_DATA    = 8'h02;
    localparam logic [7:0] PFS_PORT5_DIR     = 8'h03;
    localparam logic [7:0] PFS_ANALOG_EN     = 8'h04;
    localparam logic [7:0] PFS_LCD_CTRL2_LO  = 8'h05;
    localparam logic [7:0] PFS_LCD_CTRL2_HI  = 8'h06;
    localparam logic [7:0] PFS_PORT6_DATA    = 8'h07;
    localparam logic [7:0] PFS_PORT7_DATA    = 8'h08;
    localparam logic [7:0] PFS_TRIG_PORT     = 8'h09;
    localparam logic [7:0] PFS_FUNC_STATUS   = 8'h0a;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PFS_TRIG_DATA_BIT = 0;
    localparam int PFS_TRIG_DIR_BIT  = 1;
    localparam int PFS_P4_PULSE0     = 0;
    localparam int PFS_P4_PULSE1     = 1;
    localparam int PFS_P4_TIMER0     = 2;
    localparam int PFS_P4_TIMER1     = 3;
    localparam int PFS_P4_TIMER2     = 4;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [6:0] PFS_PORT4_RST     = 7'h00;
    localparam logic [3:0] PFS_PORT5_RST     = 4'h0;
    localparam logic [3:0] PFS_ANALOG_EN_RST = 4'hf;
    localparam logic [7:0] PFS_BYTE_RST      = 8'h00;
    localparam logic [1:0] PFS_TRIG_RST      = 2'h0;

    // ------------------------------------------------------------
    // One-time PROM geometry
    // ------------------------------------------------------------
    localparam int          PFS_PROM_DEPTH   = 49152;
    localparam logic [16:0] PFS_PROG_BASE    = 17'h14000;
    localparam logic [16:0] PFS_PROG_LAST    = 17'h1ffff;
    localparam logic [23:0] PFS_ROM_BASE     = 24'hff4000;
    localparam logic [23:0] PFS_ROM_LAST     = 24'hffffff;
    localparam logic [7:0]  PFS_BLANK_BYTE   = 8'hff;

    // ------------------------------------------------------------
    // External reset hold, machine cycles
    // ------------------------------------------------------------
    localparam int PFS_RESET_HOLD_CYCLES = 5;

endpackage : pfs_pkg

// [logic/pfs_port_function_select.sv]
`timescale 1ns/1ns
// Functional notes
// - Pin 4.0 is port until pulse 0 enabled
// - Pin 4.1 is port until pulse 1 enabled
// - Timer 0 pin port unless timer output enabled
// - Timer 1 pin port unless timer output enabled
// - Timer 2 pin port unless timer output enabled
// - Timer pins feed their event count inputs
// - Trigger pin starts both pulse generators
// - Same trigger pin feeds converter start
// - Interrupt 7 sampled from timer 0 pin
// - Port five pins port or analog channel
// - Ports six/seven segments unless port enabled
// - Blank PROM reads ones, programming only clears
// - Programming mode acts as parallel EPROM
// - ROM FF4000 maps to programming 14000
module pfs_port_function_select
    import pfs_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    // Peripheral side
    input  wire logic [1:0]  pulseOutEn,
    input  wire logic [1:0]  pulseWave,
    input  wire logic [2:0]  timerOutEn,
    input  wire logic [2:0]  timerOut,
    input  wire logic [15:0] lcdSegment,
    output logic      [2:0]  timerEventIn,
    output logic             pulseTrigger,
    output logic             adcTrigger,
    output logic             extIrqLine7,
    output logic      [3:0]  analogChanSel,
    // Trigger pin
    input  wire logic        trigPinIn,
    output logic             trigPinOut,
    output logic             trigPinOe,
    // Port four pins
    input  wire logic [6:0]  port4PinIn,
    output logic      [6:0]  port4PinOut,
    output logic      [6:0]  port4PinOe,
    // Port five pins
    input  wire logic [3:0]  port5PinIn,
    output logic      [3:0]  port5PinOut,
    output logic      [3:0]  port5PinOe,
    // Ports six and seven pins
    input  wire logic [15:0] lcdPinIn,
    output logic      [15:0] lcdPinOut,
    output logic      [15:0] lcdPinOe,
    // Programming mode and normal ROM fetch
    input  wire logic        progMode,
    input  wire logic [16:0] progAddr,
    input  wire logic [7:0]  progDataIn,
    input  wire logic        chipEnable_n,
    input  wire logic        outputEnable_n,
    input  wire logic        programStrobe_n,
    input  wire logic        progVoltageHigh,
    output logic      [7:0]  progDataOut,
    output logic             progDataOe,
    input  wire logic [23:0] romAddr,
    output logic      [7:0]  romData
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [6:0]  port4Data;
    logic [6:0]  port4Dir;
    logic [3:0]  port5Data;
    logic [3:0]  port5Dir;
    logic [3:0]  analogEn;
    logic [15:0] lcdCtrlTwo;
    logic [15:0] lcdPortData;
    logic [1:0]  trigPort;

    wire wrPort4Data = regWrite && (regAddr == PFS_PORT4_DATA);
    wire wrPort4Dir  = regWrite && (regAddr == PFS_PORT4_DIR);
    wire wrPort5Data = regWrite && (regAddr == PFS_PORT5_DATA);
    wire wrPort5Dir  = regWrite && (regAddr == PFS_PORT5_DIR);
    wire wrAnalogEn  = regWrite && (regAddr == PFS_ANALOG_EN);
    wire wrLcdLo     = regWrite && (regAddr == PFS_LCD_CTRL2_LO);
    wire wrLcdHi     = regWrite && (regAddr == PFS_LCD_CTRL2_HI);
    wire wrPort6     = regWrite && (regAddr == PFS_PORT6_DATA);
    wire wrPort7     = regWrite && (regAddr == PFS_PORT7_DATA);
    wire wrTrig      = regWrite && (regAddr == PFS_TRIG_PORT);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port4Data   <= PFS_PORT4_RST;
            port4Dir    <= PFS_PORT4_RST;
            port5Data   <= PFS_PORT5_RST;
            port5Dir    <= PFS_PORT5_RST;
            analogEn    <= PFS_ANALOG_EN_RST;
            lcdCtrlTwo  <= {PFS_BYTE_RST, PFS_BYTE_RST};
            lcdPortData <= {PFS_BYTE_RST, PFS_BYTE_RST};
            trigPort    <= PFS_TRIG_RST;
        end else begin
            if (wrPort4Data) port4Data         <= regWrData[6:0];
            if (wrPort4Dir)  port4Dir          <= regWrData[6:0];
            if (wrPort5Data) port5Data         <= regWrData[3:0];
            if (wrPort5Dir)  port5Dir          <= regWrData[3:0];
            if (wrAnalogEn)  analogEn          <= regWrData[3:0];
            if (wrLcdLo)     lcdCtrlTwo[7:0]   <= regWrData;
            if (wrLcdHi)     lcdCtrlTwo[15:8]  <= regWrData;
            if (wrPort6)     lcdPortData[7:0]  <= regWrData;
            if (wrPort7)     lcdPortData[15:8] <= regWrData;
            if (wrTrig)      trigPort          <= regWrData[1:0];
        end
    end

    // ------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------
    // Peripheral owner per port-four bit; bits 5 and 6 are open-drain port only
    wire [6:0] p4PeriphEn = {2'b00, timerOutEn, pulseOutEn};
    wire [6:0] p4PeriphVal = {2'b00, timerOut, pulseWave};
    wire [6:0] p4OpenDrain = 7'h60;

    logic [6:0]  next_port4PinOut;
    logic [6:0]  next_port4PinOe;
    logic [3:0]  next_port5PinOut;
    logic [3:0]  next_port5PinOe;
    logic [15:0] next_lcdPinOut;
    logic [15:0] next_lcdPinOe;

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_port4
            // Enabled peripheral wins over data and direction
            assign next_port4PinOut[gi] = progMode ? 1'b0 :
                p4PeriphEn[gi] ? p4PeriphVal[gi] :
                p4OpenDrain[gi] ? 1'b0 : port4Data[gi];
            assign next_port4PinOe[gi] = progMode ? 1'b0 :
                p4PeriphEn[gi] ? 1'b1 :
                p4OpenDrain[gi] ? (port4Dir[gi] & ~port4Data[gi]) : port4Dir[gi];
        end
        for (gi = 0; gi < 4; gi++) begin : g_port5
            // Analog channel: digital driver off
            assign next_port5PinOut[gi] = port5Data[gi];
            assign next_port5PinOe[gi]  = ~progMode & ~analogEn[gi] & port5Dir[gi];
        end
        for (gi = 0; gi < 16; gi++) begin : g_lcd
            // Open drain as port: only ever pulls low
            assign next_lcdPinOut[gi] = lcdCtrlTwo[gi] ? 1'b0 : lcdSegment[gi];
            assign next_lcdPinOe[gi]  = progMode ? 1'b0 :
                lcdCtrlTwo[gi] ? ~lcdPortData[gi] : 1'b1;
        end
    endgenerate

    // Trigger pin is only a port output when software asks for it
    wire next_trigPinOut = trigPort[PFS_TRIG_DATA_BIT];
    wire next_trigPinOe  = ~progMode & trigPort[PFS_TRIG_DIR_BIT];

    // ------------------------------------------------------------
    // Pin and peripheral outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            port4PinOut   <= '0;
            port4PinOe    <= '0;
            port5PinOut   <= '0;
            port5PinOe    <= '0;
            lcdPinOut     <= '0;
            lcdPinOe      <= '0;
            trigPinOut    <= 1'b0;
            trigPinOe     <= 1'b0;
            timerEventIn  <= '0;
            pulseTrigger  <= 1'b0;
            adcTrigger    <= 1'b0;
            extIrqLine7   <= 1'b0;
            analogChanSel <= PFS_ANALOG_EN_RST;
        end else begin
            port4PinOut[1:0] <= next_port4PinOut[1:0];
            port4PinOe[1:0]  <= next_port4PinOe[1:0];
            port4PinOut[2]   <= next_port4PinOut[2];
            port4PinOe[2]    <= next_port4PinOe[2];
            port4PinOut[3]   <= next_port4PinOut[3];
            port4PinOe[3]    <= next_port4PinOe[3];
            port4PinOut[6:4] <= next_port4PinOut[6:4];
            port4PinOe[6:4]  <= next_port4PinOe[6:4];
            port5PinOut      <= next_port5PinOut;
            port5PinOe       <= next_port5PinOe;
            lcdPinOut        <= next_lcdPinOut;
            lcdPinOe         <= next_lcdPinOe;
            trigPinOut       <= next_trigPinOut;
            trigPinOe        <= next_trigPinOe;
            // Pin level seen even when own timer drives it
            timerEventIn     <= port4PinIn[PFS_P4_TIMER2:PFS_P4_TIMER0];
            pulseTrigger     <= trigPinIn;
            adcTrigger       <= trigPinIn;
            extIrqLine7      <= port4PinIn[PFS_P4_TIMER0];
            analogChanSel    <= analogEn;
        end
    end

    // ------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------
    // Input bits read the pin; analog bits read zero
    wire [6:0] port4Rd = (port4Data & port4Dir) | (port4PinIn & ~port4Dir);
    wire [3:0] port5Rd = ((port5Data & port5Dir) | (port5PinIn & ~port5Dir)) & ~analogEn;
    wire [15:0] lcdRd  = lcdPinIn & lcdCtrlTwo;
    wire [7:0] funcStatus = {3'b000, timerOutEn, pulseOutEn};

    logic [7:0] next_regRdData;
    always_comb begin
        next_regRdData = 8'h00;
        unique case (regAddr)
            PFS_PORT4_DATA:   next_regRdData = {1'b0, port4Rd};
            PFS_PORT4_DIR:    next_regRdData = {1'b0, port4Dir};
            PFS_PORT5_DATA:   next_regRdData = {4'h0, port5Rd};
            PFS_PORT5_DIR:    next_regRdData = {4'h0, port5Dir};
            PFS_ANALOG_EN:    next_regRdData = {4'h0, analogEn};
            PFS_LCD_CTRL2_LO: next_regRdData = lcdCtrlTwo[7:0];
            PFS_LCD_CTRL2_HI: next_regRdData = lcdCtrlTwo[15:8];
            PFS_PORT6_DATA:   next_regRdData = lcdRd[7:0];
            PFS_PORT7_DATA:   next_regRdData = lcdRd[15:8];
            PFS_TRIG_PORT:    next_regRdData = {6'h00, trigPinIn, trigPort[PFS_TRIG_DIR_BIT]};
            PFS_FUNC_STATUS:  next_regRdData = funcStatus;
            default:          next_regRdData = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRead ? next_regRdData : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // One-time PROM array
    // ------------------------------------------------------------
    // Array holds programmed (cleared) bits, so a blank cell is all zero here
    logic [7:0] promCleared [PFS_PROM_DEPTH];

    initial begin
        for (int i = 0; i < PFS_PROM_DEPTH; i++) begin
            promCleared[i] = 8'h00;
        end
    end

    wire        progInRange = (progAddr >= PFS_PROG_BASE) && (progAddr <= PFS_PROG_LAST);
    wire [16:0] progOffset  = progAddr - PFS_PROG_BASE;
    wire [15:0] progIndex   = progOffset[15:0];
    wire        romInRange  = (romAddr >= PFS_ROM_BASE) && (romAddr <= PFS_ROM_LAST);
    wire [23:0] romOffset   = romAddr - PFS_ROM_BASE;
    wire [15:0] romIndex    = romOffset[15:0];

    // Programming needs chip enable, strobe and the high voltage together
    wire progWrite = progMode && !chipEnable_n && !programStrobe_n
                     && progVoltageHigh && progInRange;
    wire progReadOut = progMode && !chipEnable_n && !outputEnable_n
                       && programStrobe_n;

    // Plain always: the power-up fill above also writes this array
    always @(posedge sys_clk) begin
        if (progWrite) begin
            // OR into cleared set: a bit can never return to one
            promCleared[progIndex] <= promCleared[progIndex] | ~progDataIn;
        end
    end

    wire [7:0] next_progDataOut = progInRange ? ~promCleared[progIndex] : PFS_BLANK_BYTE;
    wire [7:0] next_romData     = romInRange ? ~promCleared[romIndex] : PFS_BLANK_BYTE;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            progDataOut <= PFS_BLANK_BYTE;
            progDataOe  <= 1'b0;
            romData     <= PFS_BLANK_BYTE;
        end else begin
            progDataOut <= next_progDataOut;
            progDataOe  <= progReadOut;
            romData     <= next_romData;
        end
    end

endmodule : pfs_port_function_select

// [logic/unused_placeholder_none.sv]
`timescale 1ns/1ns

// [test/pfs_pin_model.sv]
`timescale 1ns/1ns
module pfs_pin_model (
    // Device drive
    input  wire logic [6:0]  port4Out,
    input  wire logic [6:0]  port4Oe,
    input  wire logic [3:0]  port5Out,
    input  wire logic [3:0]  port5Oe,
    input  wire logic [15:0] lcdOut,
    input  wire logic [15:0] lcdOe,
    input  wire logic        trigOut,
    input  wire logic        trigOe,
    // Board drive
    input  wire logic [6:0]  extPort4,
    input  wire logic [3:0]  extPort5,
    input  wire logic        extTrig,
    // Resolved levels
    output logic      [6:0]  port4In,
    output logic      [3:0]  port5In,
    output logic      [15:0] lcdIn,
    output logic             trigIn
);
    // ----
    // Pin resolution
    // ----
    // Board drives only released pins, so no contention is modelled
    assign port4In = (port4Oe & port4Out) | (~port4Oe & extPort4);
    assign port5In = (port5Oe & port5Out) | (~port5Oe & extPort5);
    // Open-drain lines float up on pull-ups
    assign lcdIn   = (lcdOe & lcdOut) | ~lcdOe;
    assign trigIn  = trigOe ? trigOut : extTrig;
endmodule : pfs_pin_model

// [test/pfs_fs_properties.sv]
`timescale 1ns/1ns
module pfs_fs_properties (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // Watched ports
    input wire logic [1:0]  pulseOutEn,
    input wire logic [1:0]  pulseWave,
    input wire logic [2:0]  timerOutEn,
    input wire logic [2:0]  timerOut,
    input wire logic [6:0]  port4PinIn,
    input wire logic [6:0]  port4PinOut,
    input wire logic [6:0]  port4PinOe,
    input wire logic        trigPinIn,
    input wire logic        pulseTrigger,
    input wire logic        adcTrigger,
    input wire logic        extIrqLine7,
    input wire logic [2:0]  timerEventIn,
    input wire logic [15:0] lcdPinOe,
    input wire logic        progMode
);
    // ----
    // Properties
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_pulse0_owns: assert property (
        pulseOutEn[0] && !progMode |=> port4PinOe[0] && port4PinOut[0] == $past(pulseWave[0]))
        else $error("pulse 0 wave not on pin");
    chk_pulse1_owns: assert property (
        pulseOutEn[1] && !progMode |=> port4PinOe[1] && port4PinOut[1] == $past(pulseWave[1]))
        else $error("pulse 1 wave not on pin");
    chk_timer0_owns: assert property (
        timerOutEn[0] && !progMode |=> port4PinOe[2] && port4PinOut[2] == $past(timerOut[0]))
        else $error("timer 0 output not on pin");
    chk_timer1_owns: assert property (
        timerOutEn[1] && !progMode |=> port4PinOe[3] && port4PinOut[3] == $past(timerOut[1]))
        else $error("timer 1 output not on pin");
    chk_timer2_owns: assert property (
        timerOutEn[2] && !progMode |=> port4PinOe[4] && port4PinOut[4] == $past(timerOut[2]))
        else $error("timer 2 output not on pin");
    chk_event_route: assert property (
        1'b1 |=> timerEventIn == $past(port4PinIn[4:2]))
        else $error("timer event inputs not from pins");
    chk_pulse_trig: assert property (
        $changed(trigPinIn) |=> pulseTrigger == $past(trigPinIn))
        else $error("pulse trigger not from pin");
    chk_adc_trig: assert property (
        $changed(trigPinIn) |=> adcTrigger == $past(trigPinIn))
        else $error("converter trigger not from pin");
    chk_irq7_route: assert property (
        $rose(port4PinIn[2]) |=> extIrqLine7)
        else $error("interrupt 7 missed pin rise");
    chk_prog_release: assert property (
        progMode |=> port4PinOe == 7'h00 && lcdPinOe == 16'h0000)
        else $error("pins driven in programming mode");
    cov_pulse_out: cover property (pulseOutEn[0] && pulseWave[0]);
    cov_trig_rise: cover property ($rose(trigPinIn));
    cov_prog_mode: cover property ($rose(progMode));
endmodule : pfs_fs_properties

bind pfs_port_function_select pfs_fs_properties i_pfs_fs_properties (
    .sys_clk, .reset_n, .pulseOutEn, .pulseWave, .timerOutEn, .timerOut, .port4PinIn,
    .port4PinOut, .port4PinOe, .trigPinIn, .pulseTrigger, .adcTrigger, .extIrqLine7,
    .timerEventIn, .lcdPinOe, .progMode);

// [test/pfs_port_function_select_tb_top.sv]
`timescale 1ns/1ns
module pfs_port_function_select_tb_top;
    import pfs_pkg::*;
    logic        sys_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, progDataIn = 8'h00, d;
    logic [1:0]  pulseOutEn = 2'h0, pulseWave = 2'h0;
    logic [2:0]  timerOutEn = 3'h0, timerOut = 3'h0;
    logic [15:0] lcdSegment = 16'ha5c3;
    logic        progMode = 1'b0, progVoltageHigh = 1'b0, extTrig = 1'b0;
    logic        chipEnable_n = 1'b1, outputEnable_n = 1'b1, programStrobe_n = 1'b1;
    logic [16:0] progAddr = 17'h00000;
    logic [23:0] romAddr = 24'h000000;
    logic [6:0]  extPort4 = 7'h00;
    logic [3:0]  extPort5 = 4'h0;
    wire logic [7:0]  regRdData, progDataOut, romData;
    wire logic [2:0]  timerEventIn;
    wire logic        pulseTrigger, adcTrigger, extIrqLine7, trigPinIn, trigPinOut, trigPinOe;
    wire logic        progDataOe;
    wire logic [3:0]  analogChanSel, port5PinIn, port5PinOut, port5PinOe;
    wire logic [6:0]  port4PinIn, port4PinOut, port4PinOe;
    wire logic [15:0] lcdPinIn, lcdPinOut, lcdPinOe;
    int n_errors = 0;
    int comparisons = 0;

    pfs_port_function_select i_pfs_port_function_select (.sys_clk, .reset_n, .regAddr,
        .regWrData, .regWrite, .regRead, .regRdData, .pulseOutEn, .pulseWave, .timerOutEn,
        .timerOut, .lcdSegment, .timerEventIn, .pulseTrigger, .adcTrigger, .extIrqLine7,
        .analogChanSel, .trigPinIn, .trigPinOut, .trigPinOe, .port4PinIn, .port4PinOut,
        .port4PinOe, .port5PinIn, .port5PinOut, .port5PinOe, .lcdPinIn, .lcdPinOut, .lcdPinOe,
        .progMode, .progAddr, .progDataIn, .chipEnable_n, .outputEnable_n, .programStrobe_n,
        .progVoltageHigh, .progDataOut, .progDataOe, .romAddr, .romData);
    pfs_pin_model i_pfs_pin_model (.port4Out(port4PinOut), .port4Oe(port4PinOe),
        .port5Out(port5PinOut), .port5Oe(port5PinOe), .lcdOut(lcdPinOut), .lcdOe(lcdPinOe),
        .trigOut(trigPinOut), .trigOe(trigPinOe), .extPort4, .extPort5, .extTrig,
        .port4In(port4PinIn), .port5In(port5PinIn), .lcdIn(lcdPinIn), .trigIn(trigPinIn));

    always #5 sys_clk = ~sys_clk;

    // ----
    // Bus and check tasks
    // ----
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask : rd
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic prog(input logic [7:0] v, input logic [7:0] exp);
        @(posedge sys_clk);
        progDataIn <= v;
        outputEnable_n <= 1'b1;
        programStrobe_n <= 1'b0;
        @(posedge sys_clk);
        programStrobe_n <= 1'b1;
        outputEnable_n <= 1'b0;
        settle();
        chk(progDataOut, exp);
    endtask : prog
    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // ----
    // Scenarios
    // ----
    task automatic t_pins();
        chk(lcdPinOut, 16'ha5c3);
        chk(lcdPinOe, 16'hffff);
        wr(PFS_PORT4_DATA, 8'h03);
        wr(PFS_PORT4_DIR, 8'h03);
        for (int i = 0; i < 2; i++) begin
            settle();
            chk(port4PinOut[i], 1'b1);
            @(posedge sys_clk);
            pulseOutEn <= 2'(1 << i);
            settle();
            chk({port4PinOe[i], port4PinOut[i]}, 2'b10);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            timerOutEn <= 3'(1 << i);
            timerOut <= 3'(1 << i);
            settle();
            chk({port4PinOe[4:2], port4PinOut[4:2]}, {3'(1 << i), 3'(1 << i)});
        end
        @(posedge sys_clk);
        timerOutEn <= 3'h0;
        extPort4 <= 7'h14;
        extTrig <= 1'b1;
        settle();
        chk(timerEventIn, 3'b101);
        chk(extIrqLine7, 1'b1);
        chk({pulseTrigger, adcTrigger}, 2'b11);
        @(posedge sys_clk);
        extTrig <= 1'b0;
        settle();
        chk({pulseTrigger, adcTrigger}, 2'b00);
    endtask : t_pins
    task automatic t_regs();
        rd(PFS_ANALOG_EN, d);
        chk(d, 8'h0f);
        rd(8'h3c, d);
        chk(d, 8'h00);
        wr(PFS_PORT5_DIR, 8'h0f);
        wr(PFS_ANALOG_EN, 8'h05);
        wr(PFS_LCD_CTRL2_HI, 8'h80);
        settle();
        chk({analogChanSel, port5PinOe}, 8'h5a);
        chk({lcdPinOe, lcdPinOut[15]}, {16'hffff, 1'b0});
        wr(PFS_PORT7_DATA, 8'h80);
        settle();
        chk(lcdPinOe[15], 1'b0);
        wr(PFS_TRIG_PORT, 8'h03);
        settle();
        chk({trigPinOe, trigPinOut, pulseTrigger, adcTrigger}, 4'hf);
        wr(PFS_TRIG_PORT, 8'h00);
        settle();
        chk({trigPinOe, pulseTrigger, adcTrigger}, 3'h0);
    endtask : t_regs
    task automatic t_prom();
        @(posedge sys_clk);
        progMode <= 1'b1;
        progVoltageHigh <= 1'b1;
        chipEnable_n <= 1'b0;
        outputEnable_n <= 1'b0;
        progAddr <= PFS_PROG_BASE;
        settle();
        chk({progDataOut, progDataOe}, {8'hff, 1'b1});
        chk({port4PinOe, lcdPinOe}, 23'h0);
        prog(8'h0f, 8'h0f);
        prog(8'hf3, 8'h03);
        @(posedge sys_clk);
        progMode <= 1'b0;
        romAddr <= PFS_ROM_BASE;
        settle();
        chk(romData, 8'h03);
        @(posedge sys_clk);
        romAddr <= PFS_ROM_LAST;
        settle();
        chk(romData, 8'hff);
    endtask : t_prom

    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_pins();
        t_regs();
        t_prom();
        test_done();
    end
    // Run needs about a hundred cycles; cut off far beyond
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : pfs_port_function_select_tb_top
